/* File: rtl/mlgp_axil_slave.sv */
// module: AXI4-Lite slave front end of the loop gain bank
`timescale 1ns/100ps
`default_nettype none
module mlgp_axil_slave
   import mlgp_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   mlgp_reg_if.slave regs
);
   typedef struct packed {
      logic awHeld;
      logic wHeld;
      logic [9:0] awIdx;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic awReady;
      logic wReady;
      logic bValid;
      logic [1:0] bResp;
      logic arReady;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
   } mlgp_axil_t;
   mlgp_axil_t st;
   mlgp_axil_t next_st;
   // ==========================================================
   // write and read channels
   always_comb
   begin
      next_st = st;
      regs.wrEn = 1'b0;
      regs.wrIdx = st.awIdx;
      regs.wrData = st.wData;
      regs.wrStrb = st.wStrb;
      regs.rdIdx = araddr[11:2];
      if (awvalid && st.awReady)
      begin
         next_st.awHeld = 1'b1;
         next_st.awIdx = awaddr[11:2];
      end
      if (wvalid && st.wReady)
      begin
         next_st.wHeld = 1'b1;
         next_st.wData = wdata;
         next_st.wStrb = wstrb;
      end
      if (st.bValid && bready)
         next_st.bValid = 1'b0;
      if (st.awHeld && st.wHeld && !st.bValid)
      begin
         regs.wrEn = 1'b1;
         next_st.awHeld = 1'b0;
         next_st.wHeld = 1'b0;
         next_st.bValid = 1'b1;
         next_st.bResp = regs.wrHit ? RESP_OKAY : RESP_SLVERR;
      end
      next_st.awReady = !next_st.awHeld && !next_st.bValid;
      next_st.wReady = !next_st.wHeld && !next_st.bValid;
      if (st.rValid && rready)
         next_st.rValid = 1'b0;
      if (arvalid && st.arReady)
      begin
         next_st.rValid = 1'b1;
         next_st.rData = regs.rdHit ? regs.rdData : 32'h00000000;
         next_st.rResp = regs.rdHit ? RESP_OKAY : RESP_SLVERR;
      end
      next_st.arReady = !next_st.rValid;
   end
   always_ff @(posedge clk)
   begin
      if (!resetn)
         st <= '0;
      else
         st <= next_st;
   end
   assign awready = st.awReady;
   assign wready = st.wReady;
   assign bvalid = st.bValid;
   assign bresp = st.bResp;
   assign arready = st.arReady;
   assign rvalid = st.rValid;
   assign rdata = st.rData;
   assign rresp = st.rResp;
endmodule // mlgp_axil_slave
`default_nettype wire

/* File: rtl/mlgp_decode.sv */
// module: automatic-gain flags and electrical speed limit
`timescale 1ns/100ps
`default_nettype none
module mlgp_decode
   import mlgp_pkg::*;
(
   input wire logic [9:0] curProp,
   input wire logic [9:0] curInteg,
   input wire logic [9:0] velProp,
   input wire logic [9:0] velInteg,
   input wire logic [13:0] maxSpeed,
   output logic [3:0] autoGain,
   output logic [11:0] speedLimitHz
);
   logic [13:0] quot;
   // ==========================================================
   // zero gain selects automatic calculation
   always_comb
   begin
      autoGain[AUTO_CPROP] = mlgp_is_auto(curProp); // R2
      autoGain[AUTO_CINTEG] = mlgp_is_auto(curInteg); // R3
      autoGain[AUTO_VPROP] = mlgp_is_auto(velProp); // R6
      autoGain[AUTO_VINTEG] = mlgp_is_auto(velInteg); // R7
      quot = maxSpeed / SPEED_DIV; // R9
      speedLimitHz = quot[11:0];
   end
endmodule // mlgp_decode
`default_nettype wire

/* File: rtl/mlgp_pkg.sv */
// package: register map, field layout and helpers of the loop gain bank
package mlgp_pkg;
   // ==========================================================
   // register indices (byte address is four times the index)
   localparam int IDX_W = 10;
   localparam logic [9:0] IDX_LOOP_A = 10'h08C;
   localparam logic [9:0] IDX_LOOP_B = 10'h08E;
   localparam logic [9:0] IDX_PROF_A = 10'h094;
   localparam logic [9:0] IDX_PROF_B = 10'h096;
   localparam logic [9:0] IDX_STATUS = 10'h0A0;
   // ==========================================================
   // field positions
   localparam int F_BEMF_HI = 30;
   localparam int F_BEMF_LO = 23;
   localparam int F_CPROP_HI = 22;
   localparam int F_CPROP_LO = 13;
   localparam int F_CINTEG_HI = 12;
   localparam int F_CINTEG_LO = 3;
   localparam int F_VPROP_A_HI = 2;
   localparam int F_VPROP_A_LO = 0;
   localparam int F_VPROP_B_HI = 30;
   localparam int F_VPROP_B_LO = 24;
   localparam int F_VINTEG_HI = 23;
   localparam int F_VINTEG_LO = 14;
   localparam int F_MAXSPD_HI = 13;
   localparam int F_MAXSPD_LO = 0;
   localparam int F_MODE_HI = 30;
   localparam int F_MODE_LO = 29;
   localparam int F_ON_HI = 28;
   localparam int F_ON_LO = 21;
   localparam int F_OFF_HI = 20;
   localparam int F_OFF_LO = 13;
   localparam int F_CLAMP_HI = 12;
   localparam int F_CLAMP_LO = 5;
   localparam int F_DUTYA_HI_HI = 4;
   localparam int F_DUTYA_HI_LO = 0;
   localparam int F_DUTYA_LO_HI = 30;
   localparam int F_DUTYA_LO_LO = 28;
   localparam int AUTO_CPROP = 0;
   localparam int AUTO_CINTEG = 1;
   localparam int AUTO_VPROP = 2;
   localparam int AUTO_VINTEG = 3;
   // ==========================================================
   // reset values and constants
   localparam logic [31:0] RST_LOOP_A = 32'h00000000;
   localparam logic [31:0] RST_LOOP_B = 32'h00000000;
   localparam logic [31:0] RST_PROF_A = 32'h00000000;
   localparam logic [31:0] RST_PROF_B = 32'h00000000;
   localparam logic [3:0] RST_AUTO = 4'hF;
   localparam logic [13:0] SPEED_DIV = 14'h0006;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      MLGP_MODE_SPEEDREF = 2'b00,
      MLGP_MODE_LINEAR = 2'b01,
      MLGP_MODE_STAIR = 2'b10,
      MLGP_MODE_FWDREV = 2'b11
   } mlgp_mode_t;
   // ==========================================================
   // helpers
   function automatic logic mlgp_is_auto(input logic [9:0] gain);
      return gain == 10'h000;
   endfunction
   function automatic logic [31:0] mlgp_merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            res[8*i +: 8] = data[8*i +: 8];
      return res;
   endfunction
endpackage

/* File: rtl/mlgp_reg_if.sv */
// interface: register access between bus slave and register bank
`timescale 1ns/100ps
`default_nettype none
interface mlgp_reg_if;
   logic wrEn;
   logic [9:0] wrIdx;
   logic [31:0] wrData;
   logic [3:0] wrStrb;
   logic wrHit;
   logic [9:0] rdIdx;
   logic [31:0] rdData;
   logic rdHit;
   modport slave(output wrEn, wrIdx, wrData, wrStrb, rdIdx,
      input wrHit, rdData, rdHit);
   modport bank(input wrEn, wrIdx, wrData, wrStrb, rdIdx,
      output wrHit, rdData, rdHit);
endinterface
`default_nettype wire

/* File: rtl/mlgp_regs.sv */
// module: loop gain and speed profile register bank, top level
// Behaviour
// R1 - back-EMF constant held in bits 30:23
// R2 - current proportional gain bits 22:13, zero auto
// R3 - current integral gain bits 12:3, zero auto
// R4 - velocity proportional top bits in 2:0
// R5 - velocity proportional low bits in 30:24
// R6 - assembled zero velocity proportional means auto
// R7 - velocity integral gain bits 23:14, zero auto
// R8 - maximum speed setting in bits 13:0
// R9 - speed limit equals setting divided by six
// R10 - profile mode selector in bits 30:29
// R11 - turn-on and turn-off duties, eight bits each
// R12 - clamp duty threshold in bits 12:5
// R13 - duty A upper five bits, 4:0
// R14 - duty A lower bits from next word
// R15 - first loop word resets to zero
// R16 - second loop word gains and parity reset zero
// R17 - every bit of the four loop and profile words reads back as written
`timescale 1ns/100ps
`default_nettype none
module mlgp_regs
   import mlgp_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic [7:0] backEmfConstant,
   output logic [9:0] currentGainProp,
   output logic [9:0] currentGainInteg,
   output logic [9:0] velocityGainProp,
   output logic [9:0] velocityGainInteg,
   output logic [13:0] maxSpeedSetting,
   output logic [11:0] maxElecSpeedHz,
   output mlgp_mode_t profileMode,
   output logic [7:0] turnOnDuty,
   output logic [7:0] turnOffDuty,
   output logic [7:0] clampDuty,
   output logic [7:0] breakpointDutyA,
   output logic [3:0] autoGain
);
   typedef struct packed {
      logic [31:0] loopA;
      logic [31:0] loopB;
      logic [31:0] profA;
      logic [31:0] profB;
      logic [3:0] auto;
      logic [11:0] speedHz;
   } mlgp_bank_t;
   mlgp_bank_t st;
   mlgp_bank_t next_st;
   logic [3:0] autoNow;
   logic [11:0] speedNow;
   mlgp_reg_if regs();
   // ==========================================================
   // bus front end
   mlgp_axil_slave u_slave (
      .clk(clk),
      .resetn(resetn),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .regs(regs)
   );
   // ==========================================================
   // gain decoding
   mlgp_decode u_decode (
      .curProp(currentGainProp),
      .curInteg(currentGainInteg),
      .velProp(velocityGainProp),
      .velInteg(velocityGainInteg),
      .maxSpeed(maxSpeedSetting),
      .autoGain(autoNow),
      .speedLimitHz(speedNow)
   );
   // ==========================================================
   // address decode and read mux
   always_comb
   begin
      regs.wrHit = 1'b1;
      unique case (regs.wrIdx)
         IDX_LOOP_A, IDX_LOOP_B, IDX_PROF_A, IDX_PROF_B, IDX_STATUS:
            regs.wrHit = 1'b1;
         default:
            regs.wrHit = 1'b0;
      endcase
      regs.rdHit = 1'b1;
      unique case (regs.rdIdx)
         IDX_LOOP_A:
            regs.rdData = st.loopA; // R17
         IDX_LOOP_B:
            regs.rdData = st.loopB; // R17
         IDX_PROF_A:
            regs.rdData = st.profA; // R17
         IDX_PROF_B:
            regs.rdData = st.profB; // R17
         IDX_STATUS:
            regs.rdData = {28'h0000000, st.auto};
         default:
         begin
            regs.rdData = 32'h00000000;
            regs.rdHit = 1'b0;
         end
      endcase
   end
   // ==========================================================
   // register storage
   always_comb
   begin
      next_st = st;
      next_st.auto = autoNow; // R6
      next_st.speedHz = speedNow; // R9
      if (regs.wrEn)
      begin
         unique case (regs.wrIdx)
            IDX_LOOP_A:
               next_st.loopA = mlgp_merge(st.loopA, regs.wrData,
                  regs.wrStrb); // R1
            IDX_LOOP_B:
               next_st.loopB = mlgp_merge(st.loopB, regs.wrData,
                  regs.wrStrb); // R8
            IDX_PROF_A:
               next_st.profA = mlgp_merge(st.profA, regs.wrData,
                  regs.wrStrb); // R10
            IDX_PROF_B:
               next_st.profB = mlgp_merge(st.profB, regs.wrData,
                  regs.wrStrb); // R14
            default:
               next_st = next_st;
         endcase
      end
   end
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         st.loopA <= RST_LOOP_A; // R15
         st.loopB <= RST_LOOP_B; // R16
         st.profA <= RST_PROF_A;
         st.profB <= RST_PROF_B;
         st.auto <= RST_AUTO;
         st.speedHz <= 12'h000;
      end
      else
         st <= next_st;
   end
   // ==========================================================
   // field outputs
   assign backEmfConstant = st.loopA[F_BEMF_HI:F_BEMF_LO]; // R1
   assign currentGainProp = st.loopA[F_CPROP_HI:F_CPROP_LO]; // R2
   assign currentGainInteg = st.loopA[F_CINTEG_HI:F_CINTEG_LO]; // R3
   assign velocityGainProp = {st.loopA[F_VPROP_A_HI:F_VPROP_A_LO],
      st.loopB[F_VPROP_B_HI:F_VPROP_B_LO]}; // R4 R5
   assign velocityGainInteg = st.loopB[F_VINTEG_HI:F_VINTEG_LO]; // R7
   assign maxSpeedSetting = st.loopB[F_MAXSPD_HI:F_MAXSPD_LO]; // R8
   assign maxElecSpeedHz = st.speedHz; // R9
   assign profileMode = mlgp_mode_t'(st.profA[F_MODE_HI:F_MODE_LO]); // R10
   assign turnOnDuty = st.profA[F_ON_HI:F_ON_LO]; // R11
   assign turnOffDuty = st.profA[F_OFF_HI:F_OFF_LO]; // R11
   assign clampDuty = st.profA[F_CLAMP_HI:F_CLAMP_LO]; // R12
   assign breakpointDutyA = {st.profA[F_DUTYA_HI_HI:F_DUTYA_HI_LO],
      st.profB[F_DUTYA_LO_HI:F_DUTYA_LO_LO]}; // R13 R14
   assign autoGain = st.auto;
   // ==========================================================
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   sequence s_wrFull(logic [9:0] idx);
      regs.wrEn && regs.wrIdx == idx && regs.wrStrb == 4'hF;
   endsequence
   sequence s_settle;
      1'b1 ##1 1'b1;
   endsequence
   a_bemf_write: assert property ( // R1
      s_wrFull(IDX_LOOP_A) |=>
      backEmfConstant == $past(regs.wrData[F_BEMF_HI:F_BEMF_LO]))
      else $error("back-EMF constant not taken from write");
   a_cprop_auto: assert property ( // R2
      s_wrFull(IDX_LOOP_A) ##1 s_settle |->
      autoGain[AUTO_CPROP] ==
      ($past(regs.wrData[F_CPROP_HI:F_CPROP_LO], 2) == 10'h000))
      else $error("current proportional auto flag wrong");
   a_cinteg_auto: assert property ( // R3
      s_wrFull(IDX_LOOP_A) ##1 s_settle |->
      autoGain[AUTO_CINTEG] ==
      ($past(regs.wrData[F_CINTEG_HI:F_CINTEG_LO], 2) == 10'h000))
      else $error("current integral auto flag wrong");
   a_vprop_high: assert property ( // R4
      s_wrFull(IDX_LOOP_A) |=> velocityGainProp[9:7] ==
      $past(regs.wrData[F_VPROP_A_HI:F_VPROP_A_LO]))
      else $error("velocity proportional top bits wrong");
   a_vprop_low: assert property ( // R5
      s_wrFull(IDX_LOOP_B) |=> velocityGainProp[6:0] ==
      $past(regs.wrData[F_VPROP_B_HI:F_VPROP_B_LO]))
      else $error("velocity proportional low bits wrong");
   a_vprop_auto: assert property ( // R6
      $stable(velocityGainProp) |->
      autoGain[AUTO_VPROP] == (velocityGainProp == 10'h000))
      else $error("velocity proportional auto flag wrong");
   a_vinteg_auto: assert property ( // R7
      s_wrFull(IDX_LOOP_B) ##1 s_settle |->
      autoGain[AUTO_VINTEG] ==
      ($past(regs.wrData[F_VINTEG_HI:F_VINTEG_LO], 2) == 10'h000))
      else $error("velocity integral auto flag wrong");
   a_speed_field: assert property ( // R8
      s_wrFull(IDX_LOOP_B) |=> maxSpeedSetting ==
      $past(regs.wrData[F_MAXSPD_HI:F_MAXSPD_LO]))
      else $error("maximum speed setting not taken");
   a_speed_scale: assert property ( // R9
      $stable(maxSpeedSetting)[*2] |->
      {2'b00, maxElecSpeedHz} == maxSpeedSetting / SPEED_DIV)
      else $error("speed limit is not setting over six");
   a_mode_write: assert property ( // R10
      s_wrFull(IDX_PROF_A) |=>
      profileMode == $past(regs.wrData[F_MODE_HI:F_MODE_LO]))
      else $error("profile mode not taken");
   a_duty_write: assert property ( // R11
      s_wrFull(IDX_PROF_A) |=>
      turnOnDuty == $past(regs.wrData[F_ON_HI:F_ON_LO]) &&
      turnOffDuty == $past(regs.wrData[F_OFF_HI:F_OFF_LO]))
      else $error("turn-on or turn-off duty not taken");
   a_clamp_write: assert property ( // R12
      s_wrFull(IDX_PROF_A) |=>
      clampDuty == $past(regs.wrData[F_CLAMP_HI:F_CLAMP_LO]))
      else $error("clamp duty not taken");
   a_dutya_high: assert property ( // R13
      s_wrFull(IDX_PROF_A) |=> breakpointDutyA[7:3] ==
      $past(regs.wrData[F_DUTYA_HI_HI:F_DUTYA_HI_LO]))
      else $error("duty A upper bits wrong");
   a_dutya_low: assert property ( // R14
      s_wrFull(IDX_PROF_B) |=> breakpointDutyA[2:0] ==
      $past(regs.wrData[F_DUTYA_LO_HI:F_DUTYA_LO_LO]))
      else $error("duty A lower bits wrong");
   a_reset_loopa: assert property ( // R15
      disable iff (1'b0) !resetn |=> st.loopA == RST_LOOP_A)
      else $error("first loop word not zero after reset");
   a_reset_loopb: assert property ( // R16
      disable iff (1'b0) !resetn |=>
      velocityGainInteg == 10'h000 && velocityGainProp == 10'h000 &&
      st.loopB[31] == 1'b0)
      else $error("second loop word gains not zero after reset");
   a_word_readback: assert property ( // R17
      s_wrFull(IDX_LOOP_B) ##1 (regs.rdIdx == IDX_LOOP_B) |->
      regs.rdData == $past(regs.wrData))
      else $error("second loop word does not read back");
   sequence s_wrLanes(logic [9:0] idx, logic [3:0] strb);
      regs.wrEn && regs.wrIdx == idx && regs.wrStrb == strb;
   endsequence
   a_lane_keep: assert property ( // R17
      s_wrLanes(IDX_LOOP_B, 4'h8) |=>
      st.loopB[23:0] == $past(st.loopB[23:0]) &&
      st.loopB[31:24] == $past(regs.wrData[31:24]))
      else $error("unstrobed bytes of second loop word changed");
   a_loop_hold: assert property ( // R17
      !(regs.wrEn && (regs.wrIdx == IDX_LOOP_A ||
      regs.wrIdx == IDX_LOOP_B)) |=>
      $stable({st.loopA, st.loopB}))
      else $error("loop word changed without a write");
   a_profile_hold: assert property ( // R17
      !(regs.wrEn && (regs.wrIdx == IDX_PROF_A ||
      regs.wrIdx == IDX_PROF_B)) |=>
      $stable({st.profA, st.profB}))
      else $error("profile word changed without a write");
   a_refused_write: assert property ( // R17
      regs.wrEn && (regs.wrIdx == IDX_STATUS || !regs.wrHit) |=>
      $stable({st.loopA, st.loopB, st.profA, st.profB}))
      else $error("status or unmapped write changed a word");
   a_miss_answer: assert property ( // R17
      regs.wrEn && !regs.wrHit |=> bvalid && bresp == RESP_SLVERR)
      else $error("unmapped write not refused");
   a_auto_reset: assert property ( // R6
      disable iff (1'b0) !resetn |=> autoGain == RST_AUTO)
      else $error("auto gain flags not all set after reset");
endmodule // mlgp_regs
`default_nettype wire

/* File: testbench/mlgp_regs_bench.sv */
// testbench: register access and field decode of the loop gain bank
`timescale 1ns/100ps
`default_nettype none
module mlgp_regs_bench
   import mlgp_pkg::*;
   ;
   // ==========================================================
   // signals and addresses
   localparam logic [11:0] A_A = {IDX_LOOP_A, 2'h0};
   localparam logic [11:0] A_B = {IDX_LOOP_B, 2'h0};
   localparam logic [11:0] A_PA = {IDX_PROF_A, 2'h0};
   localparam logic [11:0] A_PB = {IDX_PROF_B, 2'h0};
   localparam logic [11:0] A_S = {IDX_STATUS, 2'h0};
   localparam logic [31:0] ALL = 32'hFFFFFFFF;
   localparam logic [31:0] NOSPD = 32'hFFFFC000;
   logic clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [11:0] awaddr, araddr, maxElecSpeedHz;
   logic [31:0] wdata, rdata, shA, shB, shPA, shPB, got, d;
   logic [3:0] wstrb, autoGain;
   logic [1:0] bresp, rresp, resp;
   logic [7:0] backEmfConstant, turnOnDuty, turnOffDuty, clampDuty;
   logic [7:0] breakpointDutyA;
   logic [9:0] currentGainProp, currentGainInteg;
   logic [9:0] velocityGainProp, velocityGainInteg;
   logic [13:0] maxSpeedSetting;
   mlgp_mode_t profileMode;
   int miscompares, samplesChecked;

   mlgp_regs mlgp_regs_i
   (
      .clk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .backEmfConstant,
      .currentGainProp, .currentGainInteg, .velocityGainProp,
      .velocityGainInteg, .maxSpeedSetting, .maxElecSpeedHz,
      .profileMode, .turnOnDuty, .turnOffDuty, .clampDuty,
      .breakpointDutyA, .autoGain
   );

   initial
      clk = 1'h0;
   always #20 clk = ~clk;

   // ==========================================================
   // compare tasks
   task automatic chk_word(input logic [31:0] g, e, input string what);
      samplesChecked++;
      if (g !== e)
      begin
         miscompares++;
         $display("ERROR at %0t: %s %h expected %h", $time, what, g, e);
      end
   endtask

   task automatic chk_resp(input logic [1:0] g, e, input string what);
      samplesChecked++;
      if (g !== e)
      begin
         miscompares++;
         $display("ERROR at %0t: %s %h expected %h", $time, what, g, e);
      end
   endtask

   task automatic chk_field(input logic [31:0] g, e, input string what);
      samplesChecked++;
      if (g !== e)
      begin
         miscompares++;
         $display("ERROR at %0t: field %s %h expected %h", $time, what,
            g, e);
      end
   endtask

   // ==========================================================
   // bus tasks and output field check
   task automatic axi_write(input logic [11:0] a, input logic [31:0] v,
      input logic [3:0] s, output logic [1:0] r);
      bit awDone;
      bit wDone;
      awDone = 0;
      wDone = 0;
      awaddr <= a;
      wdata <= v;
      wstrb <= s;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!(awDone && wDone))
      begin
         @(posedge clk);
         if (!awDone && awready)
         begin
            awDone = 1;
            awvalid <= 1'h0;
         end
         if (!wDone && wready)
         begin
            wDone = 1;
            wvalid <= 1'h0;
         end
      end
      do
         @(posedge clk);
      while (!bvalid);
      r = bresp;
      bready <= 1'h0;
      @(posedge clk);
   endtask

   task automatic axi_read(input logic [11:0] a, output logic [31:0] v,
      output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do
         @(posedge clk);
      while (!arready);
      arvalid <= 1'h0;
      while (!rvalid)
         @(posedge clk);
      v = rdata;
      r = rresp;
      rready <= 1'h0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] v,
      input logic [3:0] s, input logic [1:0] er);
      logic [31:0] m;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      axi_write(a, v, s, resp);
      chk_resp(resp, er, "write response");
      case (a[11:2])
         IDX_LOOP_A: shA = (shA & ~m) | (v & m);
         IDX_LOOP_B: shB = (shB & ~m) | (v & m);
         IDX_PROF_A: shPA = (shPA & ~m) | (v & m);
         IDX_PROF_B: shPB = (shPB & ~m) | (v & m);
         default: m = '0;
      endcase
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e, mask,
      input logic [1:0] er);
      axi_read(a, got, resp);
      chk_resp(resp, er, "read response");
      chk_word(got & mask, e & mask, "read data");
   endtask

   task automatic chk_outputs();
      logic [9:0] vp;
      vp = {shA[2:0], shB[30:24]};
      chk_field(32'(backEmfConstant), 32'(shA[30:23]), "emf");
      chk_field(32'(currentGainProp), 32'(shA[22:13]), "cprop");
      chk_field(32'(currentGainInteg), 32'(shA[12:3]), "cinteg");
      chk_field(32'(velocityGainProp), 32'(vp), "vprop");
      chk_field(32'(velocityGainInteg), 32'(shB[23:14]), "vinteg");
      chk_field(32'(maxSpeedSetting), 32'(shB[13:0]), "maxspd");
      chk_field(32'(maxElecSpeedHz), 32'(shB[13:0]) / 6, "hz");
      chk_field(32'(profileMode), 32'(shPA[30:29]), "mode");
      chk_field(32'(turnOnDuty), 32'(shPA[28:21]), "on");
      chk_field(32'(turnOffDuty), 32'(shPA[20:13]), "off");
      chk_field(32'(clampDuty), 32'(shPA[12:5]), "clamp");
      chk_field(32'(breakpointDutyA), {24'h0, shPA[4:0], shPB[30:28]},
         "dutya");
      chk_field(32'(autoGain), 32'({shB[23:14] == 0, vp == 0,
         shA[12:3] == 0, shA[22:13] == 0}), "auto");
   endtask

   // ==========================================================
   // verdict and watchdog
   task automatic test_done();
      $display("checks %0d mismatches %0d", samplesChecked, miscompares);
      if (miscompares == 0 && samplesChecked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      repeat (4000) @(posedge clk);
      miscompares++;
      $display("ERROR at %0t: watchdog expired", $time);
      test_done();
   end

   // ==========================================================
   // test sequence
   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      {shA, shB, shPA, shPB} = '0;
      resetn = 1'h0;
      repeat (5) @(posedge clk);
      resetn <= 1'h1;
      repeat (2) @(posedge clk);
      chk_outputs();
      rd(A_A, 32'h0, ALL, RESP_OKAY);
      rd(A_B, 32'h0, NOSPD, RESP_OKAY);
      rd(A_S, 32'h0000000F, ALL, RESP_OKAY);
      $display("test reset values done");
      wr(A_A, 32'hD5A53C6B, 4'hF, RESP_OKAY);
      wr(A_B, 32'hA5D22710, 4'hF, RESP_OKAY);
      rd(A_A, shA, ALL, RESP_OKAY);
      rd(A_B, shB, ALL, RESP_OKAY);
      chk_outputs();
      wr(A_B, 32'h7FFFFFFF, 4'hF, RESP_OKAY);
      chk_outputs();
      $display("test loop fields done");
      wr(A_A + 12'h3, 32'h80000008, 4'hF, RESP_OKAY);
      rd(A_A, shA, ALL, RESP_OKAY);
      chk_outputs();
      wr(A_B, 32'h80000000, 4'h8, RESP_OKAY);
      rd(A_B, shB, ALL, RESP_OKAY);
      chk_outputs();
      wr(A_S, ALL, 4'hF, RESP_OKAY);
      rd(A_S, 32'h00000005, ALL, RESP_OKAY);
      $display("test automatic gain done");
      for (int m = 0; m < 4; m++)
      begin
         d = 32'h9ABCDEF5 + m * 32'h13579BDF;
         d[30:29] = m[1:0];
         wr(A_PA, d, 4'hF, RESP_OKAY);
         chk_outputs();
      end
      wr(A_PB, 32'h50000000, 4'hF, RESP_OKAY);
      chk_outputs();
      rd(A_PA, shPA, ALL, RESP_OKAY);
      rd(A_PB, shPB, ALL, RESP_OKAY);
      $display("test profile fields done");
      wr(12'h240, ALL, 4'hF, RESP_SLVERR);
      rd(12'h240, 32'h0, ALL, RESP_SLVERR);
      chk_outputs();
      $display("test unmapped access done");
      resetn <= 1'h0;
      repeat (2) @(posedge clk);
      resetn <= 1'h1;
      repeat (2) @(posedge clk);
      {shA, shB, shPA, shPB} = '0;
      rd(A_A, 32'h0, ALL, RESP_OKAY);
      rd(A_B, 32'h0, NOSPD, RESP_OKAY);
      chk_outputs();
      $display("test second reset done");
      test_done();
   end
endmodule // mlgp_regs_bench
`default_nettype wire
